//--- src/tmc_pkg.sv
package tmc_pkg;
   // register byte addresses on the avalon word bus (word aligned)
   localparam logic [3:0] addr_status_control = 4'h0;
   localparam logic [3:0] addr_counter_high = 4'h4;
   localparam logic [3:0] addr_counter_low = 4'h8;
   localparam logic [3:0] addr_modulo_high = 4'hc;
   localparam logic [3:0] addr_modulo_low = 4'h0;
   localparam logic [4:0] addr_modulo_low_full = 5'h10;
   // status/control field positions
   localparam int pos_overflow_flag = 7;
   localparam int pos_overflow_irq_enable = 6;
   localparam int pos_center_align_select = 5;
   localparam int pos_clock_source_hi = 4;
   localparam int pos_clock_source_lo = 3;
   localparam int pos_prescale_hi = 2;
   // reset values and the free-run count limit
   localparam logic [15:0] reset_counter = 16'h0000;
   localparam logic [15:0] reset_modulo = 16'h0000;
   localparam logic [15:0] counter_all_ones = 16'hffff;
   localparam logic [7:0] reset_prescale_count = 8'h00;
   // clock source codes
   localparam logic [1:0] clk_src_off = 2'h0;
   localparam logic [1:0] clk_src_bus = 2'h1;
   localparam logic [1:0] clk_src_fixed = 2'h2;
   localparam logic [1:0] clk_src_ext = 2'h3;

   typedef struct packed {
      logic overflow_irq_enable;
      logic center_align_select;
      logic [1:0] clock_source_field;
      logic [2:0] prescale_field;
   } tmc_ctrl_type;

   typedef enum logic [1:0] {
      tmc_clear_idle,
      tmc_clear_armed
   } tmc_clear_state_type;
endpackage

//--- src/tmc_timer_main_counter_ctrl.sv
module tmc_timer_main_counter_ctrl
   import tmc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic i_fixed_system_clock,
   input wire logic i_external_timer_clock,
   input wire logic i_debug_mode,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq,
   output logic [15:0] o_counter,
   output logic o_count_down,
   output logic o_overflow_event
);

   tmc_ctrl_type ctrl;
   tmc_clear_state_type clear_state;
   logic overflow_flag;
   logic [15:0] counter;
   logic [15:0] modulo;
   logic [7:0] modulo_high_buf;
   logic [7:0] modulo_low_buf;
   logic mod_high_pending;
   logic mod_low_pending;
   logic count_down;
   logic [7:0] prescale_count;
   logic [1:0] fixed_sync;
   logic [1:0] ext_sync;
   logic [1:0] dbg_sync;
   logic fixed_prev;
   logic ext_prev;
   logic latch_valid;
   logic [15:0] latch_value;
   logic ack;

   // one wait cycle: request answered at the edge where ack is high
   wire access = (i_avs_read | i_avs_write) & ~ack;
   // reads act on the first edge so data stands when waitrequest drops
   wire rd = i_avs_read & ~ack;
   wire wr = i_avs_write & ack;
   wire sel_sc = i_avs_address == {1'b0, addr_status_control};
   wire sel_cnth = i_avs_address == {1'b0, addr_counter_high};
   wire sel_cntl = i_avs_address == {1'b0, addr_counter_low};
   wire sel_modh = i_avs_address == {1'b0, addr_modulo_high};
   wire sel_modl = i_avs_address == addr_modulo_low_full;
   wire wr_sc = wr & sel_sc;
   wire wr_cnt = wr & (sel_cnth | sel_cntl);
   wire rd_cnt = rd & (sel_cnth | sel_cntl);
   wire wr_modh = wr & sel_modh;
   wire wr_modl = wr & sel_modl;
   wire debug = dbg_sync[1];

   // source selection then prescaler
   wire fixed_tick = fixed_sync[1] & ~fixed_prev;
   wire ext_tick = ext_sync[1] & ~ext_prev;
   logic src_tick;
   always_comb begin
      case (ctrl.clock_source_field)
         clk_src_off: src_tick = 1'b0;
         clk_src_bus: src_tick = 1'b1;
         clk_src_fixed: src_tick = fixed_tick;
         clk_src_ext: src_tick = ext_tick;
         default: src_tick = 1'b0;
      endcase
   end
   wire [7:0] prescale_mask = 8'((9'h001 << ctrl.prescale_field) - 9'h001);
   wire prescale_wrap = (prescale_count & prescale_mask) == prescale_mask;
   wire count_tick = src_tick & prescale_wrap & ~debug;

   // counting
   wire free_run = modulo == reset_modulo;
   wire at_limit = free_run ? counter == counter_all_ones : counter == modulo;
   wire mod_blocked = mod_high_pending | mod_low_pending;
   logic [15:0] next_counter;
   logic next_down;
   logic overflow_hit;
   always_comb begin
      next_counter = counter;
      next_down = count_down;
      overflow_hit = 1'b0;
      if (!ctrl.center_align_select) begin
         next_down = 1'b0;
         if (at_limit) begin
            next_counter = reset_counter;
            overflow_hit = 1'b1;
         end else begin
            next_counter = 16'(counter + 16'h0001);
         end
      end else if (count_down) begin
         if (counter == reset_counter || counter == 16'h0001) begin
            next_down = 1'b0;
         end
         next_counter = (counter == reset_counter) ? 16'h0001 :
                        16'(counter - 16'h0001);
      end else if (!free_run && counter == modulo) begin
         next_down = 1'b1;
         next_counter = 16'(counter - 16'h0001);
         overflow_hit = 1'b1;
      end else begin
         next_counter = 16'(counter + 16'h0001);
      end
   end
   wire overflow_event = count_tick & overflow_hit & ~mod_blocked;

   // read data
   wire [15:0] cnt_view = latch_valid ? latch_value : counter;
   wire [7:0] sc_view = {overflow_flag, ctrl.overflow_irq_enable,
                         ctrl.center_align_select, ctrl.clock_source_field,
                         ctrl.prescale_field};
   logic [7:0] read_byte;
   always_comb begin
      read_byte = 8'h00;
      if (sel_sc) read_byte = sc_view;
      if (sel_cnth) read_byte = cnt_view[15:8];
      if (sel_cntl) read_byte = cnt_view[7:0];
      if (sel_modh) read_byte = modulo_high_buf;
      if (sel_modl) read_byte = modulo_low_buf;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         fixed_sync <= 2'h0;
         ext_sync <= 2'h0;
         dbg_sync <= 2'h0;
         fixed_prev <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         // first stage feeds only the second stage
         fixed_sync <= {fixed_sync[0], i_fixed_system_clock};
         ext_sync <= {ext_sync[0], i_external_timer_clock};
         dbg_sync <= {dbg_sync[0], i_debug_mode};
         fixed_prev <= fixed_sync[1];
         ext_prev <= ext_sync[1];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ack <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         ack <= access;
         if (rd) o_avs_readdata <= {24'h00_0000, read_byte};
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctrl <= '0;
         prescale_count <= reset_prescale_count;
      end else begin
         if (wr_sc) ctrl <= i_avs_writedata[pos_overflow_irq_enable:0];
         if (wr_sc) prescale_count <= reset_prescale_count;
         else if (src_tick && !debug) prescale_count <= 8'(prescale_count + 8'h01);
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         counter <= reset_counter;
         count_down <= 1'b0;
      end else if (wr_cnt) begin
         counter <= reset_counter;
         count_down <= 1'b0;
      end else if (count_tick) begin
         counter <= next_counter;
         count_down <= next_down;
      end
   end

   // modulo bytes go to buffers; both must land before the limit moves
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         modulo <= reset_modulo;
         modulo_high_buf <= 8'h00;
         modulo_low_buf <= 8'h00;
         mod_high_pending <= 1'b0;
         mod_low_pending <= 1'b0;
      end else if (wr_sc) begin
         modulo_high_buf <= modulo[15:8];
         modulo_low_buf <= modulo[7:0];
         mod_high_pending <= 1'b0;
         mod_low_pending <= 1'b0;
      end else if (wr_modh) begin
         modulo_high_buf <= i_avs_writedata[7:0];
         if (mod_low_pending) begin
            modulo <= {i_avs_writedata[7:0], modulo_low_buf};
            mod_low_pending <= 1'b0;
         end else begin
            mod_high_pending <= 1'b1;
         end
      end else if (wr_modl) begin
         modulo_low_buf <= i_avs_writedata[7:0];
         if (mod_high_pending) begin
            modulo <= {modulo_high_buf, i_avs_writedata[7:0]};
            mod_high_pending <= 1'b0;
         end else begin
            mod_low_pending <= 1'b1;
         end
      end
   end

   // counter read latch
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         latch_valid <= 1'b0;
         latch_value <= reset_counter;
      end else if (wr_cnt || wr_sc) begin
         latch_valid <= 1'b0;
      end else if (rd_cnt && !debug) begin
         if (!latch_valid) begin
            latch_valid <= 1'b1;
            latch_value <= counter;
         end else begin
            latch_valid <= 1'b0;
         end
      end
   end

   // overflow flag and its two-step clear
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         overflow_flag <= 1'b0;
         clear_state <= tmc_clear_idle;
      end else if (overflow_event) begin
         overflow_flag <= 1'b1; // set beats clear
         clear_state <= tmc_clear_idle;
      end else begin
         case (clear_state)
            tmc_clear_idle: begin
               if (rd && sel_sc && overflow_flag) begin
                  clear_state <= tmc_clear_armed;
               end
            end
            tmc_clear_armed: begin
               if (wr_sc) begin
                  if (!i_avs_writedata[pos_overflow_flag]) begin
                     overflow_flag <= 1'b0;
                  end
                  clear_state <= tmc_clear_idle;
               end
            end
            default: clear_state <= tmc_clear_idle;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
         o_counter <= reset_counter;
         o_count_down <= 1'b0;
         o_overflow_event <= 1'b0;
      end else begin
         // registered: rises with the flag on an overflow, falls one cycle after the flag clears
         o_irq <= (overflow_flag | overflow_event)
                  & ctrl.overflow_irq_enable;
         o_counter <= counter;
         o_count_down <= count_down;
         o_overflow_event <= overflow_event;
      end
   end

   assign o_avs_waitrequest = ~ack;

endmodule // tmc_timer_main_counter_ctrl

//--- tb/tmc_checker.sv
module tmc_checker
   import tmc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic i_fixed_system_clock,
   input wire logic i_external_timer_clock,
   input wire logic i_debug_mode,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_irq,
   input wire logic [15:0] o_counter,
   input wire logic o_count_down,
   input wire logic o_overflow_event
);
   // shadow of control bits, taken at the accepting edge like the design
   logic [1:0] src;
   logic ie;
   logic ca;
   wire ctl_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h00;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         src <= clk_src_off;
         ie <= 1'h0;
         ca <= 1'h0;
      end else if (ctl_wr) begin
         src <= i_avs_writedata[4:3];
         ie <= i_avs_writedata[6];
         ca <= i_avs_writedata[5];
      end
   end
   default clocking dc @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   sequence req_wait;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   // writes excluded: a counter write legally zeroes the count
   sequence quiet;
      src == clk_src_off && !i_avs_write;
   endsequence
   a_wait_one: assert property (req_wait |=> !o_avs_waitrequest)
      else $error("wait state longer than one cycle");
   a_count_step: assert property ($changed(o_counter) |->
      o_counter == 16'h0000 || o_counter == $past(o_counter) + 16'h0001 ||
      o_counter == $past(o_counter) - 16'h0001)
      else $error("counter jumped");
   a_stop_hold: assert property (quiet [*4] |-> $stable(o_counter))
      else $error("counter moved with no clock");
   a_debug_hold: assert property (i_debug_mode [*5] |-> $stable(o_counter))
      else $error("counter moved in debug");
   a_wrap_zero: assert property (o_overflow_event && !ca |->
      ##[0:2] o_counter == 16'h0000)
      else $error("up overflow without wrap to zero");
   a_center_down: assert property (o_overflow_event && ca |->
      ##[0:2] o_count_down)
      else $error("center overflow without turning down");
   a_irq_masked: assert property (!ie [*2] |-> !o_irq)
      else $error("interrupt while disabled");
   a_irq_raise: assert property (ie && o_overflow_event |-> ##[0:1] o_irq)
      else $error("no interrupt on overflow");
endmodule // tmc_checker

bind tmc_timer_main_counter_ctrl tmc_checker u_checker (
   .i_clock(i_clock), .i_rst(i_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata),
   .i_fixed_system_clock(i_fixed_system_clock),
   .i_external_timer_clock(i_external_timer_clock),
   .i_debug_mode(i_debug_mode), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq),
   .o_counter(o_counter), .o_count_down(o_count_down),
   .o_overflow_event(o_overflow_event)
);

//--- tb/tb_timer_main_counter_ctrl.sv
`define CHK(s, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   fail_count++; $display("Error %s expected %h seen %h", s, e, g); end end
module tb_timer_main_counter_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] c;
      logic [15:0] d;
   } tmc_row_type;
   // control byte and count gained over 1024 bus cycles
   tmc_row_type rows [11] = '{
      '{8'h08, 16'h0400}, '{8'h09, 16'h0200}, '{8'h0a, 16'h0100},
      '{8'h0b, 16'h0080}, '{8'h0c, 16'h0040}, '{8'h0d, 16'h0020},
      '{8'h0e, 16'h0010}, '{8'h0f, 16'h0008}, '{8'h10, 16'h0080},
      '{8'h19, 16'h0080}, '{8'h00, 16'h0000}};
   logic clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0;
   logic fx = 1'h0, ex = 1'h0, dg = 1'h0, wq, irq, dn, ev;
   logic [4:0] ad = 5'h00;
   logic [31:0] wd = 32'h0, rdat;
   logic [15:0] cnt, c0, v, mx;
   logic [7:0] q;
   logic [2:0] ph = 3'h0;
   int fail_count = 0, samples_checked = 0, n, ke, kd;
   initial forever #12.5 clk = ~clk;
   // slow clock at 1/8 rate, pin clock at exactly 1/4, the fastest allowed
   always @(posedge clk) begin
      ph <= ph + 3'h1;
      fx <= ph[2];
      ex <= ph[1];
   end
   tmc_timer_main_counter_ctrl u_dut (.i_clock(clk), .i_rst(rst),
      .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_fixed_system_clock(fx),
      .i_external_timer_clock(ex), .i_debug_mode(dg), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wq), .o_irq(irq), .o_counter(cnt),
      .o_count_down(dn), .o_overflow_event(ev));
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic limit(input int lim);
      if (n >= lim) begin
         fail_count++;
         end_sim();
      end
   endtask
   // request held until waitrequest is seen low; read data taken there
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      ad <= a;
      wd <= {24'h0, d};
      wr <= w;
      rd <= !w;
      n = 0;
      do begin @(posedge clk); n++; end while (wq !== 1'h0 && n < 50);
      limit(50);
      q = rdat[7:0];
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   task automatic rd16;
      bus(1'h0, 5'h04, 8'h00);
      v[15:8] = q;
      bus(1'h0, 5'h08, 8'h00);
      v[7:0] = q;
   endtask
   task automatic setup(input logic [7:0] m, input logic [7:0] c);
      bus(1'h1, 5'h00, 8'h00);
      bus(1'h1, 5'h04, 8'h00);
      bus(1'h1, 5'h0c, 8'h00);
      bus(1'h1, 5'h10, m);
      bus(1'h1, 5'h00, c);
   endtask
   task automatic wait_ev(input int lim);
      n = 0;
      while (ev !== 1'h1 && n < lim) begin @(negedge clk); n++; end
      limit(lim);
   endtask
   task automatic span(input int cyc);
      mx = 16'h0;
      ke = 0;
      kd = 0;
      repeat (cyc) begin
         @(negedge clk);
         if (cnt > mx) mx = cnt;
         if (ev === 1'h1) ke++;
         if (dn === 1'h1) kd++;
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         bus(1'h0, 5'(i * 4), 8'h00);
         `CHK("reset value", 8'h00, q)
      end
      foreach (rows[i]) begin
         bus(1'h1, 5'h00, rows[i].c);
         repeat (16) @(negedge clk);
         c0 = cnt;
         repeat (1024) @(negedge clk);
         `CHK("count gain", rows[i].d, 16'(cnt - c0))
      end
      bus(1'h1, 5'h00, 8'h08);
      bus(1'h0, 5'h08, 8'h00);
      c0 = cnt;
      mx[7:0] = q;
      repeat (300) @(negedge clk);
      bus(1'h0, 5'h04, 8'h00);
      `CHK("latched", 1'h1, 16'({q, mx[7:0]} - c0 + 16'h8) < 16'h10)
      bus(1'h0, 5'h08, 8'h00);
      bus(1'h1, 5'h04, 8'h00);
      repeat (20) @(negedge clk);
      bus(1'h0, 5'h04, 8'h00);
      `CHK("latch restart", 8'h00, q)
      bus(1'h0, 5'h08, 8'h00);
      @(posedge clk);
      dg <= 1'h1;
      repeat (10) @(negedge clk);
      rd16();
      c0 = v;
      repeat (200) @(negedge clk);
      rd16();
      `CHK("frozen", c0, v)
      @(posedge clk);
      dg <= 1'h0;
      setup(8'h07, 8'h48);
      wait_ev(40);
      span(40);
      `CHK("up limit", 16'h0007, mx)
      `CHK("irq", 1'h1, irq)
      bus(1'h1, 5'h00, 8'h40);
      bus(1'h0, 5'h00, 8'h00);
      `CHK("no read no clear", 8'hc0, q)
      bus(1'h1, 5'h00, 8'h40);
      bus(1'h0, 5'h00, 8'h00);
      `CHK("cleared", 8'h40, q)
      bus(1'h1, 5'h00, 8'hc0);
      bus(1'h0, 5'h00, 8'h00);
      `CHK("write one", 8'h40, q)
      `CHK("irq off", 1'h0, irq)
      setup(8'h07, 8'h08);
      wait_ev(40);
      bus(1'h0, 5'h00, 8'h00);
      wait_ev(40);
      bus(1'h1, 5'h00, 8'h08);
      bus(1'h0, 5'h00, 8'h00);
      `CHK("restarted clear", 1'h1, q[7])
      bus(1'h1, 5'h0c, 8'h00);
      span(40);
      `CHK("held overflow", 0, ke)
      bus(1'h1, 5'h10, 8'h07);
      wait_ev(40);
      setup(8'h07, 8'h28);
      span(60);
      `CHK("center limit", 16'h0007, mx)
      `CHK("down count", 1'h1, kd > 0)
      @(posedge clk);
      rst <= 1'h1;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      bus(1'h0, 5'h00, 8'h00);
      `CHK("second reset", 8'h00, q)
      setup(8'h00, 8'h08);
      wait_ev(70000);
      bus(1'h0, 5'h00, 8'h00);
      `CHK("full wrap", 8'h88, q)
      end_sim();
   end
endmodule // tb_timer_main_counter_ctrl
